// >>> hw/level_sync.v
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// two-flop synchroniser, one per bit
// ----------------------------------------------------------------
module level_sync #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b1}}
) (
   input wire i_clk, // core clock
   input wire i_reset_n, // async reset, active low
   input wire [WIDTH-1:0] i_async, // pin levels
   output wire [WIDTH-1:0] o_sync // synchronised levels
);
   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : bit_sync
         reg stage1;
         reg stage2;
         always @(posedge i_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
               stage1 <= RESET_VALUE[g];
               stage2 <= RESET_VALUE[g];
            end else begin
               stage1 <= i_async[g];
               stage2 <= stage1;
            end
         end
         assign o_sync[g] = stage2;
      end
   endgenerate
endmodule

`default_nettype wire

// >>> hw/reset_supervisor_nand_tree.v
// Overview of operation
// - manual reset low forces system reset
// - reset held for pulse width after release
// - drive bidirectional reset low on undervoltage
// - external low on bidir pin resets device
// - power-up reset held pulse width after bidir high
// - system reset output ORs all sources
// - por loads values; run once supply good
// - trip-point limit registers initialised to 0x46 and 0x64
// - por initialises listed register set
// - bidir pin low holds registers, converter idle
// - soft reset spares test and analog registers
// - config bit 4 starts soft reset, self-clears
// - strap sampled and latched at power-up
// - test mode held until power removed
// - address pin becomes tree output in test
// - tree output toggles per raised input
// - configuration powers on as 0x25
// - interrupt mask powers on as zero
`timescale 1ns/1ps
`default_nettype none
`include "reset_supervisor_regs.vh"

module reset_supervisor_nand_tree #(
   parameter [`PULSE_COUNT_WIDTH-1:0] RESET_PULSE_CYCLES = `RESET_PULSE_CYCLES
) (
   input wire I_CLK, // core clock, 50 MHz
   input wire I_RESET_N, // power-on reset, async, active low
   input wire I_MANUAL_RESET_N_IN, // push-button reset pin
   input wire I_BIDIR_RESET_N, // level seen on the bidirectional reset pin
   output wire O_BIDIR_RESET_N, // drive value for the bidirectional reset pin
   output wire O_BIDIR_RESET_OE, // high while the bidirectional pin is driven
   input wire I_VCC_BELOW_THRESHOLD, // main supply comparator, high when low
   input wire I_MONITORED_SUPPLY_LOW, // monitored supply comparator, high when low
   output reg O_SYSTEM_RESET_OUT_N, // stretched system reset, active low
   input wire I_FAN_SPEED_TEST_STRAP, // strap level on the fan speed pin
   input wire I_SERIAL_DATA, // serial data pin level
   input wire I_SERIAL_CLOCK, // serial clock pin level
   input wire I_GENERAL_LOGIC_INPUT, // general purpose input pin level
   input wire I_ADDR_SELECT, // address select level in normal use
   output reg O_ADDR_SELECT_TEST_OUT, // tree output in test mode
   output wire O_ADDR_SELECT_OE, // high while the address pin is driven
   output reg O_TEST_MODE, // test mode latched
   input wire I_REG_WRITE, // register write strobe from the serial slave
   input wire [2:0] I_REG_SELECT, // register picked by the write
   input wire [7:0] I_REG_WDATA, // write data
   output reg [7:0] O_CONFIG, // configuration register
   output reg [7:0] O_INT_STATUS, // interrupt status register
   output reg [7:0] O_STATUS_MIRROR, // status mirror register
   output reg [7:0] O_INT_MASK, // interrupt mask register
   output reg [7:0] O_TEST_REG, // test register
   output reg [7:0] O_ANALOG_OUT, // analog output register
   output reg [7:0] O_LOCAL_TRIP, // local trip-point register
   output reg [7:0] O_REMOTE_TRIP, // remote trip-point register
   input wire [7:0] I_INT_STATUS_SET, // status bits set by monitoring
   output reg O_CONVERTER_ENABLE, // converter sequencing allowed
   output reg O_SOFT_RESET_PULSE // one cycle when soft reset acts
);

   // ----------------------------------------------------------------
   // register selections
   // ----------------------------------------------------------------
   localparam [2:0] SEL_CONFIG = 3'h0;
   localparam [2:0] SEL_MASK = 3'h1;
   localparam [2:0] SEL_TEST = 3'h2;
   localparam [2:0] SEL_ANALOG = 3'h3;
   localparam [2:0] SEL_LOCAL = 3'h4;
   localparam [2:0] SEL_REMOTE = 3'h5;
   localparam [2:0] SEL_STATUS_CLR = 3'h6;

   // reset stretcher states
   localparam [1:0] ST_HOLD = 2'h0;
   localparam [1:0] ST_STRETCH = 2'h1;
   localparam [1:0] ST_RUN = 2'h2;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   wire [4:0] sync_pins;
   wire [4:0] sync_reset_val;
   wire manual_n;
   wire bidir_n;
   wire vcc_low;
   wire mon_low;
   wire strap;

   // rails come up low-supply asserted so the first cycles hold reset
   assign sync_reset_val = `PIN_SYNC_RESET;

   // bit order, msb first: strap, monitored supply, main supply, pin, manual
   level_sync #(
      .WIDTH(5),
      .RESET_VALUE(`PIN_SYNC_RESET)
   ) u_sync (
      .i_clk(I_CLK),
      .i_reset_n(I_RESET_N),
      .i_async({I_FAN_SPEED_TEST_STRAP, I_MONITORED_SUPPLY_LOW,
                I_VCC_BELOW_THRESHOLD, I_BIDIR_RESET_N, I_MANUAL_RESET_N_IN}),
      .o_sync(sync_pins)
   );

   assign manual_n = sync_pins[0];
   assign bidir_n = sync_pins[1];
   assign vcc_low = sync_pins[2];
   assign mon_low = sync_pins[3];
   assign strap = sync_pins[4];

   // ----------------------------------------------------------------
   // reset sources
   // ----------------------------------------------------------------
   // undervoltage drives pin
   // the comparator input is used raw so the pin falls without sync delay
   // open drain: the pin is only ever pulled low, never driven high
   assign O_BIDIR_RESET_N = 1'b0;
   assign O_BIDIR_RESET_OE = I_VCC_BELOW_THRESHOLD;

   wire reset_request;
   assign reset_request = !manual_n || !bidir_n || vcc_low || mon_low;

   // ----------------------------------------------------------------
   // pulse stretcher
   // ----------------------------------------------------------------
   reg [1:0] state;
   reg [1:0] next_state;
   reg [`PULSE_COUNT_WIDTH-1:0] count;
   reg [`PULSE_COUNT_WIDTH-1:0] next_count;

   // a request during the stretch drops back to hold, restarting the count
   always @* begin
      next_state = state;
      next_count = count;
      case (state)
         ST_HOLD: begin
            next_count = {`PULSE_COUNT_WIDTH{1'b0}};
            if (!reset_request) begin
               next_state = ST_STRETCH;
            end
         end
         ST_STRETCH: begin
            if (reset_request) begin
               next_state = ST_HOLD;
            end else if (count >= RESET_PULSE_CYCLES - 1'b1) begin
               next_state = ST_RUN;
            end else begin
               next_count = count + 1'b1;
            end
         end
         ST_RUN: begin
            if (reset_request) begin
               next_state = ST_HOLD;
            end
         end
         default: begin
            next_state = ST_HOLD;
         end
      endcase
   end

   // the output is registered from next_state so it cannot glitch
   // power-up stretch
   always @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         state <= ST_HOLD;
         count <= {`PULSE_COUNT_WIDTH{1'b0}};
         O_SYSTEM_RESET_OUT_N <= 1'b0;
      end else begin
         state <= next_state;
         count <= next_count;
         O_SYSTEM_RESET_OUT_N <= (next_state == ST_RUN);
      end
   end

   // ----------------------------------------------------------------
   // test mode strap
   // ----------------------------------------------------------------
   reg strap_taken;
   reg [1:0] fill;

   // no exit until power off
   // the strap is only trusted once the synchroniser has flushed its
   // reset value, otherwise a fitted strap would read as absent
   always @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         fill <= 2'h0;
         strap_taken <= 1'b0;
         O_TEST_MODE <= 1'b0;
      end else if (fill != `SYNC_DEPTH) begin
         fill <= fill + 2'h1;
      end else if (!strap_taken) begin
         strap_taken <= 1'b1;
         O_TEST_MODE <= strap;
      end
   end

   // ----------------------------------------------------------------
   // nand tree
   // ----------------------------------------------------------------
   // under the walking-one pattern the tree acts as an inverted parity
   // chain, so it is built as one; pins pass the usual two flops, which
   // only adds a few cycles to a static board test
   wire [2:0] tree_sync;
   wire [`TREE_WIDTH-1:0] tree_in;
   wire [`TREE_WIDTH:0] chain;

   level_sync #(
      .WIDTH(3),
      .RESET_VALUE(`TREE_SYNC_RESET)
   ) u_tree_sync (
      .i_clk(I_CLK),
      .i_reset_n(I_RESET_N),
      .i_async({I_GENERAL_LOGIC_INPUT, I_SERIAL_CLOCK, I_SERIAL_DATA}),
      .o_sync(tree_sync)
   );

   // manual reset is the input farthest from the output and is already synchronised
   assign tree_in = {tree_sync, manual_n};
   assign chain[0] = 1'b1;

   genvar t;
   generate
      for (t = 0; t < `TREE_WIDTH; t = t + 1) begin : tree_stage
         assign chain[t+1] = chain[t] ^ tree_in[t];
      end
   endgenerate

   assign O_ADDR_SELECT_OE = O_TEST_MODE;

   always @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_ADDR_SELECT_TEST_OUT <= 1'b0;
      end else begin
         O_ADDR_SELECT_TEST_OUT <= O_TEST_MODE & chain[`TREE_WIDTH];
      end
   end

   // ----------------------------------------------------------------
   // register set
   // ----------------------------------------------------------------
   wire hard_reset;
   wire soft_reset;
   wire wr_config;

   // the pin reset is a level: writes are refused for as long as it is low
   // pin low holds defaults
   assign hard_reset = !bidir_n;
   assign wr_config = I_REG_WRITE && (I_REG_SELECT == SEL_CONFIG);
   assign soft_reset = O_CONFIG[`CFG_SOFT_RESET_BIT];

   // converter stays idle through any later supply fault as well
   // converter runs once supply good
   always @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_CONVERTER_ENABLE <= 1'b0;
         O_SOFT_RESET_PULSE <= 1'b0;
      end else begin
         O_CONVERTER_ENABLE <= !hard_reset && !vcc_low && !mon_low;
         O_SOFT_RESET_PULSE <= soft_reset;
      end
   end

   always @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_CONFIG <= `CONFIG_POR;
         O_INT_STATUS <= `INT_STATUS_POR;
         O_STATUS_MIRROR <= `STATUS_MIRROR_POR;
         O_INT_MASK <= `INT_MASK_POR;
         O_LOCAL_TRIP <= `LOCAL_TRIP_POR;
         O_REMOTE_TRIP <= `REMOTE_TRIP_POR;
      end else if (hard_reset || soft_reset) begin
         O_CONFIG <= `CONFIG_POR;
         O_INT_STATUS <= `INT_STATUS_POR;
         O_STATUS_MIRROR <= `STATUS_MIRROR_POR;
         O_INT_MASK <= `INT_MASK_POR;
         O_LOCAL_TRIP <= `LOCAL_TRIP_POR;
         O_REMOTE_TRIP <= `REMOTE_TRIP_POR;
      end else begin
         if (wr_config) begin
            O_CONFIG <= I_REG_WDATA;
         end
         if (I_REG_WRITE && I_REG_SELECT == SEL_MASK) begin
            O_INT_MASK <= I_REG_WDATA;
         end
         // trip points freeze once the lock bit is set
         if (I_REG_WRITE && I_REG_SELECT == SEL_LOCAL && !O_CONFIG[`CFG_LOCK_BIT]) begin
            O_LOCAL_TRIP <= I_REG_WDATA;
         end
         if (I_REG_WRITE && I_REG_SELECT == SEL_REMOTE && !O_CONFIG[`CFG_LOCK_BIT]) begin
            O_REMOTE_TRIP <= I_REG_WDATA;
         end
         // set wins over a clear in the same cycle
         if (I_REG_WRITE && I_REG_SELECT == SEL_STATUS_CLR) begin
            O_INT_STATUS <= I_INT_STATUS_SET;
            O_STATUS_MIRROR <= I_INT_STATUS_SET;
         end else begin
            O_INT_STATUS <= O_INT_STATUS | I_INT_STATUS_SET;
            O_STATUS_MIRROR <= O_STATUS_MIRROR | I_INT_STATUS_SET;
         end
      end
   end

   // test and analog registers only see power-on and pin resets
   always @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_TEST_REG <= `TEST_REG_POR;
         O_ANALOG_OUT <= `ANALOG_OUT_POR;
      end else if (hard_reset) begin
         O_TEST_REG <= `TEST_REG_POR;
         O_ANALOG_OUT <= `ANALOG_OUT_POR;
      end else begin
         if (I_REG_WRITE && I_REG_SELECT == SEL_TEST) begin
            O_TEST_REG <= I_REG_WDATA;
         end
         if (I_REG_WRITE && I_REG_SELECT == SEL_ANALOG) begin
            O_ANALOG_OUT <= I_REG_WDATA;
         end
      end
   end

   wire unused_ok;
   assign unused_ok = &{1'b0, I_ADDR_SELECT, sync_reset_val};

endmodule

`default_nettype wire

// >>> hw/reset_supervisor_regs.vh
`ifndef RESET_SUPERVISOR_REGS_VH
`define RESET_SUPERVISOR_REGS_VH

// ----------------------------------------------------------------
// reset values of the registers kept by this block
// ----------------------------------------------------------------
`define CONFIG_POR 8'h25
`define INT_STATUS_POR 8'h00
`define STATUS_MIRROR_POR 8'h00
`define INT_MASK_POR 8'h00
`define TEST_REG_POR 8'h00
`define ANALOG_OUT_POR 8'h00
`define LOCAL_TRIP_POR 8'h46
`define REMOTE_TRIP_POR 8'h64

// ----------------------------------------------------------------
// configuration field positions
// ----------------------------------------------------------------
`define CFG_SOFT_RESET_BIT 4
`define CFG_LOCK_BIT 3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 20
`define RESET_PULSE_WIDTH_NS 140000
// 140 us at the 20 ns core clock period
`define RESET_PULSE_CYCLES 16'h1B58
`define PULSE_COUNT_WIDTH 16
`define SYNC_DEPTH 2'h2

// ----------------------------------------------------------------
// synchroniser reset levels and tree size
// ----------------------------------------------------------------
// strap absent, both supplies low, pin low, manual released
`define PIN_SYNC_RESET 5'h0D
`define TREE_SYNC_RESET 3'h0
`define TREE_WIDTH 4

`endif

// >>> tb/board_model.sv
`timescale 1ns/1ps
`default_nettype none
module board_model (
   input wire logic i_drive_oe, // device pulls the pin
   input wire logic i_drive_val, // device drive value
   input wire logic i_ext_low, // outside party pulls low
   input wire logic i_strap_sel, // strap fitted high
   output wire logic o_pin_level, // resolved pin level
   output wire logic o_strap_level // strap pin level
);
   // open-drain reset wire
   // pull-up wins only while no party pulls low
   assign o_pin_level = ((i_drive_oe && !i_drive_val) || i_ext_low) ? 1'b0 : 1'b1;
   assign o_strap_level = i_strap_sel;
endmodule
`default_nettype wire

// >>> tb/reset_supervisor_sva.sv
`timescale 1ns/1ps
`default_nettype none
module reset_supervisor_sva #(
   parameter [15:0] RESET_PULSE_CYCLES = 16'h0008
) (
   input wire I_CLK, // core clock
   input wire I_RESET_N, // power-on reset
   input wire I_MANUAL_RESET_N_IN, // push-button
   input wire I_BIDIR_RESET_N, // pin level
   input wire I_VCC_BELOW_THRESHOLD, // main supply low
   input wire I_MONITORED_SUPPLY_LOW, // monitored supply low
   input wire I_SERIAL_DATA, // tree input
   input wire I_SERIAL_CLOCK, // tree input
   input wire I_GENERAL_LOGIC_INPUT, // tree input
   input wire O_BIDIR_RESET_N, // pin drive
   input wire O_BIDIR_RESET_OE, // pin enable
   input wire O_SYSTEM_RESET_OUT_N, // stretched reset
   input wire O_ADDR_SELECT_TEST_OUT, // tree output
   input wire O_ADDR_SELECT_OE, // tree enable
   input wire O_TEST_MODE, // test mode
   input wire [7:0] O_CONFIG, // configuration
   input wire O_CONVERTER_ENABLE, // converter allowed
   input wire O_SOFT_RESET_PULSE // soft reset strobe
);
   logic quiet;
   logic parity_n;
   logic [15:0] rel_cnt;
   // ----------------------------------------------------------------
   // cycles since every reset source went quiet
   // ----------------------------------------------------------------
   assign quiet = I_MANUAL_RESET_N_IN && I_BIDIR_RESET_N && !I_VCC_BELOW_THRESHOLD
      && !I_MONITORED_SUPPLY_LOW;
   assign parity_n = ~(I_MANUAL_RESET_N_IN ^ I_SERIAL_DATA ^ I_SERIAL_CLOCK
      ^ I_GENERAL_LOGIC_INPUT);
   always @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         rel_cnt <= 16'h0000;
      end else if (!quiet) begin
         rel_cnt <= 16'h0000;
      end else if (rel_cnt != 16'hFFFF) begin
         rel_cnt <= rel_cnt + 16'h0001;
      end
   end
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RESET_N);
   a_manual_low: assert property (
      !I_MANUAL_RESET_N_IN [*4] |=> !O_SYSTEM_RESET_OUT_N)
      else $error("system reset missing under manual reset");
   a_supply_low: assert property (
      (I_VCC_BELOW_THRESHOLD || I_MONITORED_SUPPLY_LOW) [*4] |=> !O_SYSTEM_RESET_OUT_N)
      else $error("system reset missing under low supply");
   a_bidir_input: assert property (
      !I_BIDIR_RESET_N [*4] |=> !O_SYSTEM_RESET_OUT_N && !O_CONVERTER_ENABLE
      && O_CONFIG == 8'h25)
      else $error("pin reset not applied");
   a_stretch_hold: assert property (
      rel_cnt >= 16'h0003 && rel_cnt <= RESET_PULSE_CYCLES |-> !O_SYSTEM_RESET_OUT_N)
      else $error("system reset released early");
   a_stretch_end: assert property (
      rel_cnt == RESET_PULSE_CYCLES + 16'h000A |-> O_SYSTEM_RESET_OUT_N)
      else $error("system reset held too long");
   a_pin_drive: assert property (
      O_BIDIR_RESET_OE == I_VCC_BELOW_THRESHOLD && !O_BIDIR_RESET_N)
      else $error("reset pin drive wrong");
   a_soft_clear: assert property (
      O_CONFIG[4] |=> O_CONFIG == 8'h25 && O_SOFT_RESET_PULSE)
      else $error("soft reset did not act and clear");
   a_mode_held: assert property (
      O_TEST_MODE |=> O_TEST_MODE)
      else $error("test mode left");
   a_tree_idle: assert property (
      O_ADDR_SELECT_OE == O_TEST_MODE && (O_TEST_MODE || !O_ADDR_SELECT_TEST_OUT))
      else $error("address pin use wrong");
   a_tree_xor: assert property (
      O_TEST_MODE && $past(O_TEST_MODE) |-> O_ADDR_SELECT_TEST_OUT == $past(parity_n, 3))
      else $error("tree output wrong");
endmodule
bind reset_supervisor_nand_tree reset_supervisor_sva #(
   .RESET_PULSE_CYCLES(RESET_PULSE_CYCLES)
) sva_i (
   .I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_MANUAL_RESET_N_IN(I_MANUAL_RESET_N_IN),
   .I_BIDIR_RESET_N(I_BIDIR_RESET_N), .I_VCC_BELOW_THRESHOLD(I_VCC_BELOW_THRESHOLD),
   .I_MONITORED_SUPPLY_LOW(I_MONITORED_SUPPLY_LOW), .I_SERIAL_DATA(I_SERIAL_DATA),
   .I_SERIAL_CLOCK(I_SERIAL_CLOCK), .I_GENERAL_LOGIC_INPUT(I_GENERAL_LOGIC_INPUT),
   .O_BIDIR_RESET_N(O_BIDIR_RESET_N), .O_BIDIR_RESET_OE(O_BIDIR_RESET_OE),
   .O_SYSTEM_RESET_OUT_N(O_SYSTEM_RESET_OUT_N),
   .O_ADDR_SELECT_TEST_OUT(O_ADDR_SELECT_TEST_OUT), .O_ADDR_SELECT_OE(O_ADDR_SELECT_OE),
   .O_TEST_MODE(O_TEST_MODE), .O_CONFIG(O_CONFIG),
   .O_CONVERTER_ENABLE(O_CONVERTER_ENABLE), .O_SOFT_RESET_PULSE(O_SOFT_RESET_PULSE)
);
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam logic [15:0] PW = 16'h0008;
   logic clk, reset_n, mr_n, vcc_low, mon_low, ext_low, strap_sel, sda, scl, general_logic_input, wr_en;
   logic [2:0] sel;
   logic [7:0] wdata, st_set;
   wire logic pin, strap, drv_n, drv_oe, sys_n, tree, tree_oe, tmode, conv, spulse;
   wire logic [7:0] cfg, ist, mir, msk, tst, ana, ltr, rtr;
   int error_cnt = 0;
   int checks_done = 0;
   board_model brd (.i_drive_oe(drv_oe), .i_drive_val(drv_n), .i_ext_low(ext_low),
      .i_strap_sel(strap_sel), .o_pin_level(pin), .o_strap_level(strap));
   reset_supervisor_nand_tree #(.RESET_PULSE_CYCLES(PW)) dut (
      .I_CLK(clk), .I_RESET_N(reset_n), .I_MANUAL_RESET_N_IN(mr_n), .I_BIDIR_RESET_N(pin),
      .O_BIDIR_RESET_N(drv_n), .O_BIDIR_RESET_OE(drv_oe), .I_VCC_BELOW_THRESHOLD(vcc_low),
      .I_MONITORED_SUPPLY_LOW(mon_low), .O_SYSTEM_RESET_OUT_N(sys_n),
      .I_FAN_SPEED_TEST_STRAP(strap), .I_SERIAL_DATA(sda), .I_SERIAL_CLOCK(scl),
      .I_GENERAL_LOGIC_INPUT(general_logic_input), .I_ADDR_SELECT(1'b0), .O_ADDR_SELECT_TEST_OUT(tree),
      .O_ADDR_SELECT_OE(tree_oe), .O_TEST_MODE(tmode), .I_REG_WRITE(wr_en),
      .I_REG_SELECT(sel), .I_REG_WDATA(wdata), .O_CONFIG(cfg), .O_INT_STATUS(ist),
      .O_STATUS_MIRROR(mir), .O_INT_MASK(msk), .O_TEST_REG(tst), .O_ANALOG_OUT(ana),
      .O_LOCAL_TRIP(ltr), .O_REMOTE_TRIP(rtr), .I_INT_STATUS_SET(st_set),
      .O_CONVERTER_ENABLE(conv), .O_SOFT_RESET_PULSE(spulse));
   always #10 clk = ~clk;
   // ----------------------------------------------------------------
   // shared helpers
   // ----------------------------------------------------------------
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // bounded wait for the stretched reset to lift, then its length is judged
   task automatic wait_rel();
      int n;
      n = 0;
      while (sys_n !== 1'b1 && n < 200) begin
         step(1);
         n++;
      end
      if (n >= 200) begin
         error_cnt++;
         $display("MISMATCH reset release expected 1 seen %b", sys_n);
         print_verdict();
      end
      chk("pulse length", 8'h01, {7'h00, n >= PW && n <= PW + 12});
   endtask
   task automatic wr(input logic [2:0] s, input logic [7:0] d);
      wr_en = 1'b1;
      sel = s;
      wdata = d;
      step(1);
      wr_en = 1'b0;
      step(1);
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_power_up(input logic s);
      reset_n = 1'b0;
      strap_sel = s;
      step(20);
      chk("config", 8'h25, cfg);
      chk("mask", 8'h00, msk);
      chk("status", 8'h00, ist | mir | tst | ana);
      chk("local trip", 8'h46, ltr);
      chk("remote trip", 8'h64, rtr);
      chk("converter", 8'h00, {7'h00, conv | sys_n});
      reset_n = 1'b1;
      wait_rel();
      step(2);
      chk("converter", 8'h01, {7'h00, conv});
      chk("test mode", {7'h00, s}, {7'h00, tmode});
      $display("power up done");
   endtask
   task automatic t_manual();
      mr_n = 1'b0;
      step(5);
      chk("system reset", 8'h00, {7'h00, sys_n});
      mr_n = 1'b1;
      wait_rel();
      $display("manual reset done");
   endtask
   task automatic t_sources();
      for (int k = 0; k < 3; k++) begin
         wr(3'h1, 8'hFF);
         ext_low = (k == 0);
         vcc_low = (k == 1);
         mon_low = (k == 2);
         step(6);
         chk("system reset", 8'h00, {7'h00, sys_n});
         chk("pin enable", {7'h00, k == 1}, {7'h00, drv_oe});
         chk("mask", (k < 2) ? 8'h00 : 8'hFF, msk);
         chk("converter", 8'h00, {7'h00, conv});
         ext_low = 1'b0;
         vcc_low = 1'b0;
         mon_low = 1'b0;
         wait_rel();
      end
      $display("reset sources done");
   endtask
   task automatic t_soft();
      wr(3'h2, 8'hA5);
      wr(3'h3, 8'h3C);
      wr(3'h1, 8'hFF);
      wr(3'h4, 8'h10);
      wr(3'h5, 8'h20);
      chk("trips written", 8'h10 ^ 8'h20, ltr ^ rtr);
      chk("local trip", 8'h10, ltr);
      st_set = 8'h01;
      step(1);
      st_set = 8'h00;
      step(1);
      chk("status", 8'h01, ist & mir);
      // a clear write in the cycle of a new set keeps the new bit
      st_set = 8'h04;
      wr(3'h6, 8'h00);
      st_set = 8'h00;
      chk("status clear", 8'h04, ist | mir);
      wr(3'h0, 8'h35);
      step(2);
      chk("config", 8'h25, cfg);
      chk("mask", 8'h00, msk | ist | mir);
      chk("local trip", 8'h46, ltr);
      chk("remote trip", 8'h64, rtr);
      chk("test reg", 8'hA5, tst);
      chk("analog", 8'h3C, ana);
      // lock bit refuses trip writes
      wr(3'h0, 8'h2D);
      wr(3'h4, 8'h10);
      wr(3'h5, 8'h20);
      chk("local trip locked", 8'h46, ltr);
      chk("remote trip locked", 8'h64, rtr);
      $display("soft reset done");
   endtask
   task automatic t_tree();
      t_power_up(1'b1);
      chk("tree enable", 8'h01, {7'h00, tree_oe});
      for (int i = 0; i < 5; i++) begin
         {general_logic_input, scl, sda, mr_n} = 4'hF >> (4 - i);
         step(4);
         chk("tree out", {7'h00, i % 2 == 0}, {7'h00, tree});
      end
      mr_n = 1'b0;
      step(5);
      mr_n = 1'b1;
      wait_rel();
      wr(3'h0, 8'h35);
      chk("test mode", 8'h01, {7'h00, tmode});
      t_power_up(1'b0);
      $display("tree test done");
   endtask
   initial begin
      {clk, reset_n, vcc_low, mon_low, ext_low, strap_sel, sda, scl, general_logic_input, wr_en} = '0;
      mr_n = 1'b1;
      sel = 3'h0;
      wdata = 8'h00;
      st_set = 8'h00;
      t_power_up(1'b0);
      t_manual();
      t_sources();
      t_soft();
      t_tree();
      print_verdict();
   end
endmodule
`default_nettype wire
